// ==== rtl/fault_supervisor_defs.vh ====
// constants for the regulator fault supervisor
`ifndef FAULT_SUPERVISOR_DEFS_VH
`define FAULT_SUPERVISOR_DEFS_VH

`define OC_COUNT_LOW      6'd15
`define OC_COUNT_HIGH     6'd60
`define OC_CNT_W          6
`define FREQ_DEFAULT_KHZ  900
`define HICCUP_HOLD_CYC   16'hFFFF
`define HICCUP_CNT_W      16

`endif

// ==== rtl/flag_sync.v ====
// two-stage synchroniser for a vector of analog comparator flags
`timescale 1ns/1ns
`default_nettype none
module flag_sync #(
  parameter W = 8
) (
  input  wire         clk_sys_i,  // system clock
  input  wire         resetn_i,   // async reset, active low
  input  wire [W-1:0] async_i,    // raw flags
  output reg  [W-1:0] sync_o      // synchronised flags
);
  reg [W-1:0] stage1;

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      stage1 <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/regulator_fault_supervisor.v ====
// fault supervisor: reset output, master shutdown, hiccup, latched faults
// Operation
// - main rail undervoltage holds reset output low, not latched
// - main rail overcurrent lowers reset only once rail is undervoltage
// - aux rail undervoltage or overcurrent leaves reset output unaffected
// - low prereg output, amp not max: keep switching, cut pulse on limit
// - low prereg output, amp at max: hiccup after 15 overcurrent events
// - high prereg output, amp at max: hiccup after 60 overcurrent events
// - one missing catch diode detection latches master shutdown, reset low
// - switch node limit latches master shutdown, reset low until cycled
// - open or grounded frequency pin selects 900 kHz default, no latch
// - pump overvoltage raises master shutdown, not latched
// - pump undervoltage raises master shutdown, released when it clears
// - open pump pins or grounded pump cap a read as pump undervoltage
// - prereg high overvoltage latches master shutdown until cycled
`timescale 1ns/1ns
`default_nettype none
`include "fault_supervisor_defs.vh"
module regulator_fault_supervisor #(
  parameter HICCUP_HOLD = `HICCUP_HOLD_CYC
) (
  input  wire clk_sys_i,              // 125 MHz system clock
  input  wire resetn_i,               // async reset, active low
  input  wire ignition_enable_i,      // ignition enable pin level
  input  wire main_ldo_uv_i,          // main rail below lower uv threshold
  input  wire main_ldo_oc_i,          // main rail overcurrent
  input  wire aux_ldo_uv_i,           // aux rail undervoltage
  input  wire aux_ldo_oc_i,           // aux rail overcurrent
  input  wire prereg_low_i,           // prereg output below 2.4 V
  input  wire err_amp_max_i,          // error amplifier at maximum
  input  wire overcurrent_event_i,    // high side current above limit
  input  wire switch_node_limit_i,    // switch node short current limit
  input  wire catch_diode_missing_i,  // missing catch diode detected
  input  wire freq_pin_fault_i,       // freq_set_sync_pin open or grounded
  input  wire pump_overvolt_i,        // pump rail overvoltage
  input  wire pump_undervolt_i,       // pump rail undervoltage
  input  wire pump_pin_open_i,        // pump rail or pump cap pin open
  input  wire pump_cap_a_gnd_i,       // pump_cap_a shorted to ground
  input  wire prereg_overvolt_high_i, // prereg high overvoltage detector
  output reg  reset_out_n_o,          // reset output, active low
  output reg  master_shutdown_reset_o,// all regulators off
  output reg  pulse_terminate_o,      // end current switch node pulse
  output reg  hiccup_o,               // hiccup mode active
  output reg  freq_default_o,         // oscillator uses default frequency
  output reg  latched_fault_o,        // a latched fault is held
  output reg  aux_fault_o             // aux rail fault, status only
);
  localparam ST_RUN    = 1'b0;
  localparam ST_HICCUP = 1'b1;
  localparam NF = 17;

  // one bit per pin flag; bit 0 is a spare held at zero
  wire [NF-1:0] raw;

  assign raw[16] = ignition_enable_i;
  assign raw[15] = main_ldo_uv_i;
  assign raw[14] = main_ldo_oc_i;
  assign raw[13] = aux_ldo_uv_i;
  assign raw[12] = aux_ldo_oc_i;
  assign raw[11] = prereg_low_i;
  assign raw[10] = err_amp_max_i;
  assign raw[9]  = overcurrent_event_i;
  assign raw[8]  = switch_node_limit_i;
  assign raw[7]  = catch_diode_missing_i;
  assign raw[6]  = freq_pin_fault_i;
  assign raw[5]  = pump_overvolt_i;
  assign raw[4]  = pump_undervolt_i;
  assign raw[3]  = pump_pin_open_i;
  assign raw[2]  = pump_cap_a_gnd_i;
  assign raw[1]  = prereg_overvolt_high_i;
  assign raw[0]  = 1'b0;
  wire [NF-1:0] s;

  flag_sync #(.W(NF)) u_sync (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .async_i   (raw),
    .sync_o    (s)
  );

  wire en       = s[16];
  wire main_uv  = s[15];
  wire main_oc  = s[14];
  wire aux_uv   = s[13];
  wire aux_oc   = s[12];
  wire vlow     = s[11];
  wire amp_max  = s[10];
  wire oc_ev    = s[9];
  wire sw_lim   = s[8];
  wire diode_ms = s[7];
  wire fpin     = s[6];
  wire cp_ov    = s[5];
  wire cp_uv    = s[4];
  wire cp_open  = s[3];
  wire cpa_gnd  = s[2];
  wire ov_high  = s[1];

  // sticky fault next value: a set in the same cycle beats the clear
  function latch_next;
    input set;
    input clr;
    input cur;
    begin
      if (set)
        latch_next = 1'b1;
      else if (clr)
        latch_next = 1'b0;
      else
        latch_next = cur;
    end
  endfunction

  // counter end test shared by the event count and the hiccup hold
  function at_limit;
    input [`HICCUP_CNT_W-1:0] cnt;
    input [`HICCUP_CNT_W-1:0] lim;
    begin
      at_limit = (cnt >= lim);
    end
  endfunction

  reg                     en_d;
  reg                     oc_d;
  reg                     latch_diode;
  reg                     latch_sw;
  reg                     latch_ov;
  reg                     state;
  reg [`OC_CNT_W-1:0]     oc_cnt;
  reg [`HICCUP_CNT_W-1:0] hic_cnt;
  reg                     next_latch_diode;
  reg                     next_latch_sw;
  reg                     next_latch_ov;
  reg                     next_state;
  reg [`OC_CNT_W-1:0]     next_oc_cnt;
  reg [`HICCUP_CNT_W-1:0] next_hic_cnt;

  // fresh enable edge clears latches; the power-up path is resetn_i
  wire en_rise  = en & ~en_d;
  wire oc_rise  = oc_ev & ~oc_d;
  wire pump_uv  = cp_uv | cp_open | cpa_gnd;
  wire latched  = latch_diode | latch_sw | latch_ov;
  // overcurrent alone never pulls reset: foldback must first drag rail into uv
  wire rst_low  = main_uv;
  wire [`OC_CNT_W-1:0] oc_limit = vlow ? `OC_COUNT_LOW
                                       : `OC_COUNT_HIGH;

  // only the diode and switch node latches pull the reset output low
  wire rst_latch = latch_diode | latch_sw;
  wire [`HICCUP_CNT_W-1:0] hold_last =
    HICCUP_HOLD[`HICCUP_CNT_W-1:0] - 16'h0001;

  // sticky faults: only a fresh enable edge or resetn_i clears them
  always @*
  begin
    next_latch_diode = latch_next(diode_ms, en_rise, latch_diode);
    next_latch_sw    = latch_next(sw_lim, en_rise, latch_sw);
    next_latch_ov    = latch_next(ov_high, en_rise, latch_ov);
  end

  // enable and overcurrent edge detectors
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      en_d <= 1'b0;
      oc_d <= 1'b0;
    end
    else
    begin
      en_d <= en;
      oc_d <= oc_ev;
    end
  end

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      latch_diode <= 1'b0;
    else
      latch_diode <= next_latch_diode;
  end

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      latch_sw <= 1'b0;
    else
      latch_sw <= next_latch_sw;
  end

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      latch_ov <= 1'b0;
    else
      latch_ov <= next_latch_ov;
  end

  // overcurrent counting and hiccup hold-off
  always @*
  begin
    next_state   = state;
    next_oc_cnt  = oc_cnt;
    next_hic_cnt = hic_cnt;
    case (state)
      ST_RUN:
      begin
        next_hic_cnt = {`HICCUP_CNT_W{1'b0}};
        if (!amp_max)
          next_oc_cnt = {`OC_CNT_W{1'b0}};
        else if (oc_rise)
        begin
          if (at_limit({10'h000, oc_cnt + 6'd1}, {10'h000, oc_limit}))
          begin
            next_state  = ST_HICCUP;
            next_oc_cnt = {`OC_CNT_W{1'b0}};
          end
          else
            next_oc_cnt = oc_cnt + 6'd1;
        end
      end
      ST_HICCUP:
      begin
        // events during the hold are ignored; counting restarts after it
        next_oc_cnt = {`OC_CNT_W{1'b0}};
        if (at_limit(hic_cnt, hold_last))
          next_state = ST_RUN;
        else
          next_hic_cnt = hic_cnt + 16'h0001;
      end
      default:
        next_state = ST_RUN;
    endcase
  end

  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state   <= ST_RUN;
      oc_cnt  <= {`OC_CNT_W{1'b0}};
      hic_cnt <= {`HICCUP_CNT_W{1'b0}};
    end
    else
    begin
      state   <= next_state;
      oc_cnt  <= next_oc_cnt;
      hic_cnt <= next_hic_cnt;
    end
  end

  // supply control outputs
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      reset_out_n_o           <= 1'b0;
      master_shutdown_reset_o <= 1'b1;
    end
    else
    begin
      master_shutdown_reset_o <= latched | cp_ov | pump_uv;
      // pump faults and prereg overvoltage leave reset to the main rail
      reset_out_n_o <= ~(rst_low | rst_latch);
    end
  end

  // switching stage outputs
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pulse_terminate_o <= 1'b0;
      hiccup_o          <= 1'b0;
      freq_default_o    <= 1'b0;
    end
    else
    begin
      // pulse-by-pulse limit keeps switching; only this pulse ends
      pulse_terminate_o <= oc_ev;
      hiccup_o          <= (state == ST_HICCUP);
      freq_default_o    <= fpin;
    end
  end

  // status outputs
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      latched_fault_o <= 1'b0;
      aux_fault_o     <= 1'b0;
    end
    else
    begin
      latched_fault_o <= latched;
      aux_fault_o     <= aux_uv | aux_oc;
    end
  end
endmodule
`default_nettype wire

// ==== dv/fault_supervisor_assertions.sv ====
// port checks for the fault supervisor, bound to its top module
`timescale 1ns/1ns
`default_nettype none
module fault_supervisor_checker (
  input wire logic clk_sys_i, resetn_i, main_ldo_uv_i,
  input wire logic overcurrent_event_i, catch_diode_missing_i,
  input wire logic switch_node_limit_i, prereg_overvolt_high_i,
  input wire logic freq_pin_fault_i, pump_overvolt_i, pump_undervolt_i,
  input wire logic pump_pin_open_i, pump_cap_a_gnd_i, reset_out_n_o,
  input wire logic master_shutdown_reset_o, freq_default_o,
  input wire logic pulse_terminate_o, latched_fault_o
);
  logic [2:0] up;  // $past is stale for a few cycles after reset
  wire pmp = pump_overvolt_i | pump_undervolt_i | pump_pin_open_i
    | pump_cap_a_gnd_i;
  wire lat = catch_diode_missing_i | switch_node_limit_i
    | prereg_overvolt_high_i;
  wire ok = up == 3'h7;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  always_ff @(posedge clk_sys_i or negedge resetn_i)
    if (!resetn_i) up <= 3'h0;
    else if (!ok) up <= up + 3'h1;
  AST_UV_LOW: assert property (ok && $past(main_ldo_uv_i, 3)
    |-> !reset_out_n_o) else $error("reset high in uv");
  AST_RST_HIGH: assert property (ok && !$past(main_ldo_uv_i, 3)
    && !latched_fault_o |-> reset_out_n_o) else $error("reset low");
  AST_LATCH_SET: assert property (ok && $past(lat, 4)
    |-> latched_fault_o) else $error("latch not set");
  AST_LATCH_OUT: assert property (latched_fault_o |->
    master_shutdown_reset_o) else $error("latch out");
  AST_LATCH_RST: assert property (ok && $past(catch_diode_missing_i
    | switch_node_limit_i, 4) |-> !reset_out_n_o) else $error("latch rst");
  AST_PUMP_ON: assert property (ok && $past(pmp, 3)
    |-> master_shutdown_reset_o) else $error("no shutdown");
  AST_PUMP_OFF: assert property (ok && !$past(pmp, 3)
    && !latched_fault_o |-> !master_shutdown_reset_o) else $error("stuck");
  AST_FREQ: assert property (ok |->
    freq_default_o == $past(freq_pin_fault_i, 3)) else $error("freq");
  AST_PULSE: assert property (ok |->
    pulse_terminate_o == $past(overcurrent_event_i, 3)) else $error("cut");
endmodule
bind regulator_fault_supervisor fault_supervisor_checker u_chk (.*);
`default_nettype wire

// ==== dv/analog_stage_model.sv ====
// switch stage comparator model giving bursts of overcurrent events
`timescale 1ns/1ns
`default_nettype none
module analog_stage_model (
  input  wire logic       clk_sys_i, // system clock
  input  wire logic [5:0] n_i,       // events in the burst
  input  wire logic       go_i,      // start a burst
  output wire logic       oc_o       // overcurrent comparator level
);
  logic [6:0] left = 7'h00;
  // one cycle high, one low: the comparator re-arms between events
  assign oc_o = left[0];
  always @(posedge clk_sys_i)
    left <= go_i ? {n_i, 1'b0} : left - {6'h00, left != 7'h00};
endmodule
`default_nettype wire

// ==== dv/tb_regulator_fault_supervisor.sv ====
// randomised self-checking bench for the fault supervisor
`timescale 1ns/1ns
`default_nettype none
module tb_regulator_fault_supervisor;
  logic clk = 1'b0, rn = 1'b0, ign = 1'b1, go = 1'b0;
  logic [10:0] r = 11'h000;
  logic [2:0] lt = 3'h0;
  logic [5:0] n = 6'h00;
  logic [31:0] s = 32'h500E;
  wire oc;
  wire [6:0] q;
  int error_cnt = 0, n_compared = 0, i, j;
  always #4 clk = ~clk;
  analog_stage_model u_oc (.clk_sys_i(clk), .n_i(n), .go_i(go), .oc_o(oc));
  regulator_fault_supervisor #(.HICCUP_HOLD(20)) u_dut (.clk_sys_i(clk),
    .resetn_i(rn), .ignition_enable_i(ign), .main_ldo_uv_i(r[0]),
    .main_ldo_oc_i(r[1]), .aux_ldo_uv_i(r[2]), .aux_ldo_oc_i(r[3]),
    .prereg_low_i(r[4]), .err_amp_max_i(r[5]), .freq_pin_fault_i(r[6]),
    .pump_overvolt_i(r[7]), .pump_undervolt_i(r[8]),
    .pump_pin_open_i(r[9]), .pump_cap_a_gnd_i(r[10]),
    .overcurrent_event_i(oc), .catch_diode_missing_i(lt[0]),
    .switch_node_limit_i(lt[1]), .prereg_overvolt_high_i(lt[2]),
    .reset_out_n_o(q[6]), .master_shutdown_reset_o(q[5]),
    .latched_fault_o(q[4]), .freq_default_o(q[3]), .aux_fault_o(q[2]),
    .hiccup_o(q[1]), .pulse_terminate_o(q[0]));
  function automatic [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // reset out, shutdown, latch, default freq, aux from level flags
  function automatic [6:0] lv(input [10:0] v);
    lv = {~v[0], |v[10:7], 1'b0, v[6], v[2] | v[3], 2'b00};
  endfunction
  task automatic chk(input [6:0] m, input [6:0] e);
    n_compared++;
    if ((q & m) !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t out %h exp %h", $time, q & m, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic burst(input [5:0] k);
    n = k;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(2 * int'(k) + 6);
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(6);
    rn = 1'b1;
    // first two are main rail overcurrent alone and aux faults alone
    for (j = 0; j < 40; j++)
    begin
      s = lfsr(s);
      r = (j == 0) ? 11'h002 : (j == 1) ? 11'h00C : s[10:0];
      cyc(5);
      chk(7'h7C, lv(r));
    end
    for (j = 0; j < 2; j++)
    begin
      r = j ? 11'h020 : 11'h030;
      burst(j ? 6'd59 : 6'd14);
      chk(7'h02, 7'h00);
      burst(6'd1);
      chk(7'h02, 7'h02);
      for (i = 0; i < 40 && q[1] !== 1'b0; i++) cyc(1);
      if (i == 40) chk(7'h02, 7'h00);
      if (i == 40) wrap_up;
    end
    r = 11'h000;
    for (j = 0; j < 3; j++)
    begin
      lt[j] = 1'b1;
      cyc(1);
      lt = 3'h0;
      cyc(12);
      chk(7'h70, (j == 2) ? 7'h70 : 7'h30);
      ign = 1'b0;
      cyc(5);
      ign = 1'b1;
      cyc(8);
      chk(7'h70, 7'h40);
    end
    wrap_up;
  end
endmodule
`default_nettype wire
